// ===== rtl/tcei_consts.vh
`ifndef TCEI_CONSTS_VH
`define TCEI_CONSTS_VH

// command port offsets
`define TCEI_A_CTRL 4'h0
`define TCEI_A_REQ 4'h1
`define TCEI_A_DMA_IN 4'h2
`define TCEI_A_DMA_OUT 4'h3
`define TCEI_A_STAT 4'h4
`define TCEI_A_ADDR_HI 4'h5
`define TCEI_A_ADDR_LO 4'h6
`define TCEI_A_IO_OUT 4'h7
`define TCEI_A_MEM_IDX 4'h8
`define TCEI_A_MEM_DATA 4'h9

// control register fields
`define TCEI_CTRL_RESET 8'h00
`define TCEI_C_FLAG1 0
`define TCEI_C_FLAG2 1
`define TCEI_C_FLAG3 2
`define TCEI_C_FLAG4 3
`define TCEI_C_RAM_DIS 4
`define TCEI_C_SW_DIS 5
`define TCEI_C_LOAD 6
`define TCEI_C_CLEAR 7

// request register fields
`define TCEI_Q_DOUT 0
`define TCEI_Q_DIN 1
`define TCEI_Q_INT 2

// state codes {bit one, bit zero}
`define TCEI_SC_FETCH 2'h0
`define TCEI_SC_EXEC 2'h1
`define TCEI_SC_DMA 2'h2
`define TCEI_SC_INT 2'h3

// io output nibble range 1..7
`define TCEI_NIB_OUT_LO 4'h1
`define TCEI_NIB_OUT_HI 4'h7

// master clock: ref_clk periods per half period, and clocks per machine cycle
`define TCEI_MCLK_HALF 3'h4
`define TCEI_CLK_PER_CYCLE 4'h8

// synchroniser vector layout
`define TCEI_SYNC_W 26
`define TCEI_S_TPA 0
`define TCEI_S_TPB 1
`define TCEI_S_SC0 2
`define TCEI_S_SC1 3
`define TCEI_S_NIB 4
`define TCEI_S_MWR 8
`define TCEI_S_MRD 9
`define TCEI_S_MA 10
`define TCEI_S_BUS 18
`endif

// ===== rtl/tcei_host.v
`timescale 1ns/1ps
`include "tcei_consts.vh"
module tcei_host (
  ref_clk,
  rst,
  cmd_addr,
  cmd_wdata,
  cmd_wr,
  cmd_rd,
  cmd_rdata,
  early_timing_pulse,
  late_timing_pulse,
  state_code_bit_zero,
  state_code_bit_one,
  opcode_nibble_bit_zero_n,
  opcode_nibble_bit_one_n,
  opcode_nibble_bit_two_n,
  opcode_nibble_bit_three_n,
  memory_write_strobe,
  memory_read_n,
  muxed_address,
  data_bus_in,
  data_bus_out,
  data_bus_oe,
  external_flag_one_n,
  external_flag_two_n,
  external_flag_three_n,
  external_flag_four_n,
  dma_out_req_n,
  dma_in_req_n,
  interrupt_n,
  clear_n,
  load_n,
  ram_card_disable,
  switch_bank_disable,
  master_clock
);
  input wire ref_clk;
  input wire rst;
  input wire [3:0] cmd_addr;
  input wire [7:0] cmd_wdata;
  input wire cmd_wr;
  input wire cmd_rd;
  output reg [7:0] cmd_rdata;
  input wire early_timing_pulse;
  input wire late_timing_pulse;
  input wire state_code_bit_zero;
  input wire state_code_bit_one;
  input wire opcode_nibble_bit_zero_n;
  input wire opcode_nibble_bit_one_n;
  input wire opcode_nibble_bit_two_n;
  input wire opcode_nibble_bit_three_n;
  input wire memory_write_strobe;
  input wire memory_read_n;
  input wire [7:0] muxed_address;
  input wire [7:0] data_bus_in;
  output reg [7:0] data_bus_out;
  output reg data_bus_oe;
  output reg external_flag_one_n;
  output reg external_flag_two_n;
  output reg external_flag_three_n;
  output reg external_flag_four_n;
  output reg dma_out_req_n;
  output reg dma_in_req_n;
  output reg interrupt_n;
  output reg clear_n;
  output reg load_n;
  output reg ram_card_disable;
  output reg switch_bank_disable;
  output reg master_clock;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: every socket input passes two flops
  wire [`TCEI_SYNC_W-1:0] pins_raw;
  reg [`TCEI_SYNC_W-1:0] sync1_ff;
  reg [`TCEI_SYNC_W-1:0] sync2_ff;
  reg [`TCEI_SYNC_W-1:0] prev_ff;

  assign pins_raw = {data_bus_in, muxed_address, memory_read_n, memory_write_strobe,
                     opcode_nibble_bit_three_n, opcode_nibble_bit_two_n,
                     opcode_nibble_bit_one_n, opcode_nibble_bit_zero_n,
                     state_code_bit_one, state_code_bit_zero,
                     late_timing_pulse, early_timing_pulse};

  // the read strobe idles high; clearing its flops low would fake a read right after reset
  wire [`TCEI_SYNC_W-1:0] sync_idle;
  assign sync_idle = {{(`TCEI_SYNC_W-1){1'b0}}, 1'b1} << `TCEI_S_MRD;

  always @(posedge ref_clk) begin
    if (rst) begin
      sync1_ff <= sync_idle;
      sync2_ff <= sync_idle;
      prev_ff <= sync_idle;
    end else begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  wire [1:0] sc_now;
  wire [3:0] nib_now;
  wire [7:0] ma_now;
  wire [7:0] ma_prev;
  wire [7:0] bus_now;
  wire tpa_fall;
  wire tpb_rise;
  wire mwr_rise;
  wire mrd_fall;
  wire mrd_active;

  assign sc_now = {sync2_ff[`TCEI_S_SC1], sync2_ff[`TCEI_S_SC0]};
  assign nib_now = ~sync2_ff[`TCEI_S_NIB+3:`TCEI_S_NIB];
  assign ma_now = sync2_ff[`TCEI_S_MA+7:`TCEI_S_MA];
  // one sample older than the pulse's end: the lines still carry the high byte there
  assign ma_prev = prev_ff[`TCEI_S_MA+7:`TCEI_S_MA];
  assign bus_now = sync2_ff[`TCEI_S_BUS+7:`TCEI_S_BUS];
  // the high byte is on the lines while the early pulse stands; take it as it ends
  assign tpa_fall = prev_ff[`TCEI_S_TPA] & ~sync2_ff[`TCEI_S_TPA];
  assign tpb_rise = ~prev_ff[`TCEI_S_TPB] & sync2_ff[`TCEI_S_TPB];
  assign mwr_rise = ~prev_ff[`TCEI_S_MWR] & sync2_ff[`TCEI_S_MWR];
  assign mrd_fall = prev_ff[`TCEI_S_MRD] & ~sync2_ff[`TCEI_S_MRD];
  assign mrd_active = ~sync2_ff[`TCEI_S_MRD];

  ////////////////////////////////////////////////////////////////////////
  // command port and software registers
  reg [7:0] ctrl_ff;
  reg [2:0] pend_ff;
  reg [7:0] dma_in_byte_ff;
  reg [7:0] dma_out_byte_ff;
  reg [7:0] stat_ff;
  reg [7:0] addr_hi_ff;
  reg [7:0] addr_lo_ff;
  reg [7:0] io_out_ff;
  reg [7:0] mem_idx_ff;
  reg [2:0] nxt_pend;
  reg [7:0] nxt_rdata;
  wire wr_ctrl;
  wire wr_req;
  wire wr_mem;
  wire dma_cycle;
  wire serve_in;
  wire serve_out;
  wire serve_int;
  wire io_out_cycle;
  wire [7:0] mem_rd_data;

  assign wr_ctrl = cmd_wr & (cmd_addr == `TCEI_A_CTRL);
  assign wr_req = cmd_wr & (cmd_addr == `TCEI_A_REQ);
  assign wr_mem = cmd_wr & (cmd_addr == `TCEI_A_MEM_DATA);
  assign dma_cycle = (sc_now == `TCEI_SC_DMA);
  // a dma cycle serves the input request first when both stand
  assign serve_in = tpb_rise & dma_cycle & pend_ff[`TCEI_Q_DIN];
  assign serve_out = tpb_rise & dma_cycle & ~pend_ff[`TCEI_Q_DIN] & pend_ff[`TCEI_Q_DOUT];
  assign serve_int = tpb_rise & (sc_now == `TCEI_SC_INT);
  // output group: execute cycle with nibble 1..7 puts a memory byte on the bus
  assign io_out_cycle = tpb_rise & (sc_now == `TCEI_SC_EXEC) & (nib_now >= `TCEI_NIB_OUT_LO)
                        & (nib_now <= `TCEI_NIB_OUT_HI);

  always @* begin
    // a new request written in the serving cycle is kept
    nxt_pend = pend_ff;
    if (serve_in) begin
      nxt_pend[`TCEI_Q_DIN] = 1'b0;
    end
    if (serve_out) begin
      nxt_pend[`TCEI_Q_DOUT] = 1'b0;
    end
    if (serve_int) begin
      nxt_pend[`TCEI_Q_INT] = 1'b0;
    end
    if (wr_req) begin
      nxt_pend = nxt_pend | cmd_wdata[`TCEI_Q_INT:`TCEI_Q_DOUT];
    end
  end

  // unmapped offsets read as zero so software can probe the map safely
  always @* begin
    case (cmd_addr)
      `TCEI_A_CTRL: nxt_rdata = ctrl_ff;
      `TCEI_A_REQ: nxt_rdata = {5'h00, pend_ff};
      `TCEI_A_DMA_IN: nxt_rdata = dma_in_byte_ff;
      `TCEI_A_DMA_OUT: nxt_rdata = dma_out_byte_ff;
      `TCEI_A_STAT: nxt_rdata = stat_ff;
      `TCEI_A_ADDR_HI: nxt_rdata = addr_hi_ff;
      `TCEI_A_ADDR_LO: nxt_rdata = addr_lo_ff;
      `TCEI_A_IO_OUT: nxt_rdata = io_out_ff;
      `TCEI_A_MEM_IDX: nxt_rdata = mem_idx_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      ctrl_ff <= `TCEI_CTRL_RESET;
      pend_ff <= 3'h0;
      dma_in_byte_ff <= 8'h00;
      dma_out_byte_ff <= 8'h00;
      stat_ff <= 8'h00;
      addr_hi_ff <= 8'h00;
      addr_lo_ff <= 8'h00;
      io_out_ff <= 8'h00;
      mem_idx_ff <= 8'h00;
      cmd_rdata <= 8'h00;
    end else begin
      pend_ff <= nxt_pend;
      cmd_rdata <= cmd_rd ? nxt_rdata : 8'h00;
      if (wr_ctrl) begin
        ctrl_ff <= cmd_wdata;
      end
      if (cmd_wr & (cmd_addr == `TCEI_A_DMA_IN)) begin
        dma_in_byte_ff <= cmd_wdata;
      end
      // a direct index write wins over the auto-increment
      if (cmd_wr & (cmd_addr == `TCEI_A_MEM_IDX)) begin
        mem_idx_ff <= cmd_wdata;
      end else if (wr_mem) begin
        mem_idx_ff <= mem_idx_ff + 8'h01;
      end
      if (serve_out) begin
        dma_out_byte_ff <= bus_now;
      end
      if (io_out_cycle) begin
        io_out_ff <= bus_now;
      end
      if (tpb_rise) begin
        stat_ff <= {2'h0, sc_now, nib_now};
      end
      if (tpa_fall) begin
        addr_hi_ff <= ma_prev;
      end
      if (mrd_fall | mwr_rise) begin
        addr_lo_ff <= ma_now;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // external read-only memory that stands in for the ram card
  tcei_mem u_mem (
    .ref_clk(ref_clk),
    .wr_en(wr_mem),
    .wr_addr(mem_idx_ff),
    .wr_data(cmd_wdata),
    .rd_addr(ma_now),
    .rd_data(mem_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // socket outputs; synchronising costs about three ref clocks of a read,
  // well inside the strobe at this master clock rate
  reg [2:0] mclk_cnt_ff;
  wire rom_drive;
  wire din_drive;

  assign din_drive = pend_ff[`TCEI_Q_DIN] & dma_cycle;
  assign rom_drive = ctrl_ff[`TCEI_C_RAM_DIS] & mrd_active & ~dma_cycle;

  always @(posedge ref_clk) begin
    if (rst) begin
      data_bus_out <= 8'h00;
      data_bus_oe <= 1'b0;
      external_flag_one_n <= 1'b1;
      external_flag_two_n <= 1'b1;
      external_flag_three_n <= 1'b1;
      external_flag_four_n <= 1'b1;
      dma_out_req_n <= 1'b1;
      dma_in_req_n <= 1'b1;
      interrupt_n <= 1'b1;
      clear_n <= 1'b1;
      load_n <= 1'b1;
      ram_card_disable <= 1'b0;
      switch_bank_disable <= 1'b0;
      master_clock <= 1'b0;
      mclk_cnt_ff <= 3'h0;
    end else begin
      // let go once the late pulse is seen: the device took the byte on that pulse's edge
      data_bus_oe <= (din_drive | rom_drive) & ~serve_in;
      data_bus_out <= din_drive ? dma_in_byte_ff : mem_rd_data;
      external_flag_one_n <= ~ctrl_ff[`TCEI_C_FLAG1];
      external_flag_two_n <= ~ctrl_ff[`TCEI_C_FLAG2];
      external_flag_three_n <= ~ctrl_ff[`TCEI_C_FLAG3];
      external_flag_four_n <= ~ctrl_ff[`TCEI_C_FLAG4];
      dma_out_req_n <= ~nxt_pend[`TCEI_Q_DOUT];
      dma_in_req_n <= ~nxt_pend[`TCEI_Q_DIN];
      interrupt_n <= ~nxt_pend[`TCEI_Q_INT];
      clear_n <= ~ctrl_ff[`TCEI_C_CLEAR];
      load_n <= ~ctrl_ff[`TCEI_C_LOAD];
      ram_card_disable <= ctrl_ff[`TCEI_C_RAM_DIS];
      switch_bank_disable <= ctrl_ff[`TCEI_C_SW_DIS];
      // eight of these clocks form one machine cycle on the device side
      if (mclk_cnt_ff == `TCEI_MCLK_HALF - 3'h1) begin
        mclk_cnt_ff <= 3'h0;
        master_clock <= ~master_clock;
      end else begin
        mclk_cnt_ff <= mclk_cnt_ff + 3'h1;
      end
    end
  end
endmodule

// ===== rtl/tcei_mem.v
`timescale 1ns/1ps
// 256-byte external memory, one write port, registered read
module tcei_mem (
  ref_clk,
  wr_en,
  wr_addr,
  wr_data,
  rd_addr,
  rd_data
);
  input wire ref_clk;
  input wire wr_en;
  input wire [7:0] wr_addr;
  input wire [7:0] wr_data;
  input wire [7:0] rd_addr;
  output reg [7:0] rd_data;

  reg [7:0] mem [0:255];

  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ===== verification/tb_tcei_host.sv
`timescale 1ns/1ps
module tb_tcei_host;
  reg ref_clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] cmd_addr = 4'h0;
  reg [7:0] cmd_wdata = 8'h00;
  reg cmd_wr = 1'b0;
  reg cmd_rd = 1'b0;
  reg [7:0] idle_ff = 8'h55;
  integer failures = 0;
  integer check_count = 0;
  integer cyc = 0;
  integer i;
  wire [7:0] cmd_rdata, data_bus_out, muxed_address, dev_byte, fetched;
  wire [1:0] sc;
  wire [3:0] nib_n;
  wire data_bus_oe, dev_oe, early_timing_pulse, late_timing_pulse, memory_write_strobe, memory_read_n;
  wire external_flag_one_n, external_flag_two_n, external_flag_three_n, external_flag_four_n;
  wire dma_out_req_n, dma_in_req_n, interrupt_n, clear_n, load_n, ram_card_disable, switch_bank_disable;
  wire master_clock;
  // a released bus flips every clock so a stale byte never passes
  wire [7:0] bus_lvl = data_bus_oe ? data_bus_out : dev_oe ? dev_byte : idle_ff;
  tcei_host dut_u (.ref_clk, .rst, .cmd_addr, .cmd_wdata, .cmd_wr, .cmd_rd, .cmd_rdata, .early_timing_pulse,
    .late_timing_pulse, .state_code_bit_zero(sc[0]), .state_code_bit_one(sc[1]),
    .opcode_nibble_bit_zero_n(nib_n[0]), .opcode_nibble_bit_one_n(nib_n[1]), .opcode_nibble_bit_two_n(nib_n[2]),
    .opcode_nibble_bit_three_n(nib_n[3]), .memory_write_strobe, .memory_read_n, .muxed_address,
    .data_bus_in(bus_lvl), .data_bus_out, .data_bus_oe, .external_flag_one_n, .external_flag_two_n,
    .external_flag_three_n, .external_flag_four_n, .dma_out_req_n, .dma_in_req_n, .interrupt_n, .clear_n,
    .load_n, .ram_card_disable, .switch_bank_disable, .master_clock);
  tcei_dev_model dev_u (.master_clock, .clear_n, .load_n, .dma_in_req_n, .dma_out_req_n, .interrupt_n,
    .ram_card_disable, .bus_lvl, .early_timing_pulse, .late_timing_pulse, .sc, .nib_n, .memory_write_strobe,
    .memory_read_n, .muxed_address, .dev_byte, .dev_oe, .fetched);
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    idle_ff <= ~idle_ff;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      summarize;
    end
  end
  ////////////////////////////////////////
  task summarize;
    begin
      if (failures == 0 && check_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_wr <= 1'b1;
      @(posedge ref_clk);
      cmd_wr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, output [7:0] v);
    begin
      @(posedge ref_clk);
      cmd_addr <= a;
      cmd_rd <= 1'b1;
      @(posedge ref_clk);
      cmd_rd <= 1'b0;
      #1 v = cmd_rdata;
    end
  endtask
  task rc(input [3:0] a, input [7:0] exp);
    reg [7:0] v;
    begin
      rd(a, v);
      chk(v, exp);
    end
  endtask
  task wrc(input [3:0] a, input [7:0] d);
    begin
      wr(a, d);
      rc(a, d);
    end
  endtask
  // bounded poll until every request has been served
  task drain;
    reg [7:0] v;
    integer j;
    begin
      v = 8'hff;
      for (j = 0; j < 200 && v !== 8'h00; j = j + 1)
        rd(4'h1, v);
      chk(v, 8'h00);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rc(4'h0, 8'h00);
    rc(4'hc, 8'h00);
    wrc(4'h0, 8'h0f);
    // here ram disable toggles only while the device is held cleared, so no read strobe straddles it; the later 8'h10 write sets it with the device running
    wrc(4'h0, 8'hc5);
    repeat (16) @(posedge ref_clk);
    wrc(4'h0, 8'hba);
    wrc(4'h0, 8'hc5);
    wrc(4'h0, 8'h00);
    repeat (3 * 64) @(posedge ref_clk);
    rc(4'h7, 8'h3c);
    rc(4'h5, 8'he1);
    for (i = 0; i < 2; i = i + 1) begin
      wrc(4'h2, i ? 8'h5a : 8'ha5);
      wr(4'h1, 8'h03);
      drain;
      rc(4'h3, i ? 8'h5a : 8'ha5);
      rc(4'h4, 8'h20);
    end
    wr(4'h1, 8'h04);
    drain;
    rc(4'h4, 8'h30);
    wr(4'h8, 8'h00);
    for (i = 0; i < 256; i = i + 1)
      wr(4'h9, 8'h96);
    rc(4'h8, 8'h00);
    wr(4'h0, 8'h10);
    repeat (3 * 64) @(posedge ref_clk);
    chk(fetched, 8'h96);
    summarize;
  end
endmodule
bind tcei_host tcei_host_properties chk_u (.ref_clk, .rst, .cmd_addr, .cmd_wdata, .cmd_wr, .late_timing_pulse,
  .state_code_bit_zero, .state_code_bit_one, .memory_read_n, .data_bus_oe, .external_flag_one_n,
  .external_flag_two_n, .external_flag_three_n, .external_flag_four_n, .dma_in_req_n, .interrupt_n, .clear_n,
  .load_n, .ram_card_disable, .switch_bank_disable, .master_clock);

// ===== verification/tcei_dev_model.sv
`timescale 1ns/1ps
// device side; one memory byte serves both dma directions
module tcei_dev_model #(
  parameter [7:0] OUT_BYTE = 8'h3c,
  parameter [7:0] HI_BYTE = 8'he1
) (
  input wire master_clock,
  input wire clear_n,
  input wire load_n,
  input wire dma_in_req_n,
  input wire dma_out_req_n,
  input wire interrupt_n,
  input wire ram_card_disable,
  input wire [7:0] bus_lvl,
  output reg early_timing_pulse = 1'b0,
  output reg late_timing_pulse = 1'b0,
  output reg [1:0] sc = 2'h0,
  output reg [3:0] nib_n = 4'hf,
  output reg memory_write_strobe = 1'b0,
  output reg memory_read_n = 1'b1,
  output reg [7:0] muxed_address = 8'h00,
  output reg [7:0] dev_byte = 8'h00,
  output reg dev_oe = 1'b0,
  output reg [7:0] fetched = 8'h00
);
  reg [2:0] cnt_ff = 3'h0;
  reg [7:0] pc_ff = 8'h00;
  reg [7:0] mem_ff = 8'h00;
  reg din_ff = 1'b0;
  wire rd = !(sc == 2'h3 || (sc == 2'h2 && din_ff));
  wire mid = cnt_ff != 3'h0 && cnt_ff < 3'h6;
  always @(posedge master_clock) begin
    if (!clear_n || !load_n) begin
      cnt_ff <= 3'h0;
      sc <= 2'h0;
      memory_read_n <= 1'b1;
      dev_oe <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 3'h1;
      early_timing_pulse <= cnt_ff == 3'h0;
      late_timing_pulse <= cnt_ff == 3'h5;
      muxed_address <= (cnt_ff == 3'h0) ? HI_BYTE : pc_ff;
      memory_read_n <= !(rd && mid);
      dev_oe <= rd && mid && !ram_card_disable;
      dev_byte <= (sc == 2'h2) ? mem_ff : OUT_BYTE;
      memory_write_strobe <= sc == 2'h2 && din_ff && cnt_ff == 3'h5;
      // sample before the late pulse: the host lets go soon after it
      if (cnt_ff == 3'h5 && sc == 2'h2 && din_ff)
        mem_ff <= bus_lvl;
      if (cnt_ff == 3'h5 && sc == 2'h0)
        fetched <= bus_lvl;
      if (cnt_ff == 3'h7) begin
        pc_ff <= pc_ff + 8'h01;
        din_ff <= !dma_in_req_n;
        nib_n <= 4'hf;
        if (!dma_in_req_n || !dma_out_req_n)
          sc <= 2'h2;
        else if (!interrupt_n)
          sc <= 2'h3;
        else if (sc == 2'h0) begin
          sc <= 2'h1;
          nib_n <= ~4'h3;
        end else
          sc <= 2'h0;
      end
    end
  end
endmodule

// ===== verification/tcei_host_properties.sv
`timescale 1ns/1ps
module tcei_host_properties (
  input wire ref_clk,
  input wire rst,
  input wire [3:0] cmd_addr,
  input wire [7:0] cmd_wdata,
  input wire cmd_wr,
  input wire late_timing_pulse,
  input wire state_code_bit_zero,
  input wire state_code_bit_one,
  input wire memory_read_n,
  input wire data_bus_oe,
  input wire external_flag_one_n,
  input wire external_flag_two_n,
  input wire external_flag_three_n,
  input wire external_flag_four_n,
  input wire dma_in_req_n,
  input wire interrupt_n,
  input wire clear_n,
  input wire load_n,
  input wire ram_card_disable,
  input wire switch_bank_disable,
  input wire master_clock
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire ctl_wr = cmd_wr && cmd_addr == 4'h0;
  wire req_wr = cmd_wr && cmd_addr == 4'h1;
  ////////////////////////////////////////
  property p_mclk;
    $changed(master_clock) |=> $stable(master_clock) [*3] ##1 $changed(master_clock);
  endproperty
  a_mclk: assert property (p_mclk) else $error("master clock half period wrong");
  property p_flags;
    ctl_wr |-> ##2 {external_flag_four_n, external_flag_three_n, external_flag_two_n, external_flag_one_n}
      == ~$past(cmd_wdata[3:0], 2);
  endproperty
  a_flags: assert property (p_flags) else $error("flag pins wrong");
  property p_ctrl;
    ctl_wr |-> ##2 {clear_n, load_n, switch_bank_disable, ram_card_disable} == ($past(cmd_wdata[7:4], 2) ^ 4'hc);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control pins wrong");
  property p_din_req;
    req_wr && cmd_wdata[1] |-> ##2 !dma_in_req_n;
  endproperty
  a_din_req: assert property (p_din_req) else $error("dma in request late");
  property p_int_req;
    req_wr && cmd_wdata[2] |-> ##2 !interrupt_n;
  endproperty
  a_int_req: assert property (p_int_req) else $error("interrupt request late");
  property p_din_done;
    $rose(dma_in_req_n) |-> $past(late_timing_pulse, 3) && $past(state_code_bit_one, 3) && !$past(state_code_bit_zero, 3);
  endproperty
  a_din_done: assert property (p_din_done) else $error("dma in released early");
  // the rom answers only while the on-board ram is silenced
  property p_rom_oe;
    $fell(memory_read_n) && ram_card_disable && !state_code_bit_one |-> ##[4:5] data_bus_oe;
  endproperty
  a_rom_oe: assert property (p_rom_oe) else $error("rom did not drive bus");
  property p_oe_src;
    data_bus_oe |-> !dma_in_req_n || ram_card_disable;
  endproperty
  a_oe_src: assert property (p_oe_src) else $error("bus driven without cause");
endmodule
